// File: inc/laser_alarm_pkg.sv
// Purpose: shared constants for the laser status and alarm logic
// Assumes: 16-bit registers, one 32-bit Avalon word per register index
// Notes:   byte address = 4 * register index
package laser_alarm_pkg;

  // register indices
  localparam logic [7:0]  IDX_FATAL_STATUS = 8'h20;
  localparam logic [7:0]  IDX_WARN_STATUS  = 8'h21;
  localparam logic [7:0]  IDX_SERVICE_MASK = 8'h28;
  localparam logic [7:0]  IDX_FAULT_MASK   = 8'h29;
  localparam logic [7:0]  IDX_ALARM_MASK   = 8'h2A;
  localparam logic [7:0]  IDX_CONFIG       = 8'h33;

  // reset values
  localparam logic [15:0] SERVICE_MASK_RST = 16'h1FBF;
  localparam logic [15:0] FAULT_MASK_RST   = 16'h000F;
  localparam logic [15:0] ALARM_MASK_RST   = 16'h0D0D;
  localparam logic [15:0] CONFIG_RST       = 16'h0000;
  localparam logic [3:0]  LATCH_RST        = 4'h0;
  localparam logic [3:0]  MISC_LATCH_RST   = 4'h2;

  // writable bits; the rest read 0
  localparam logic [15:0] SERVICE_MASK_WR  = 16'h1FFF;
  localparam logic [15:0] FAULT_MASK_WR    = 16'h0F2F;
  localparam logic [15:0] ALARM_MASK_WR    = 16'h0F0F;
  localparam logic [15:0] CONFIG_WR        = 16'h0006;

  // field positions
  localparam int          BIT_SERVICE      = 15;
  localparam int          BIT_ALARM        = 14;
  localparam int          BIT_FAULT        = 13;
  localparam int          BIT_OUT_OFF      = 12;
  localparam int          BIT_EXEC_ERR     = 7;
  localparam int          BIT_COMM_ERR     = 6;
  localparam int          BIT_RESTART      = 5;
  localparam int          BIT_COMM_RESET   = 4;
  localparam int          LIVE_LSB         = 8;
  localparam int          MISC_LSB         = 4;
  localparam int          LATCH_LSB        = 0;
  localparam int          CFG_SHUTDOWN_BIT = 1;
  localparam int          CFG_TUNE_ALARM_BIT = 2;

  // bus handshake states
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } bus_state_t;

endpackage

// File: verification/host_model.sv
// Purpose: host side of the register bus, one access at a time
// Assumes: slave answers through waitrequest; bench timeout guards a hang
// Notes:   answer read right after each rising edge, before that edge's updates land
`timescale 1ns/100ps
module host_model #(
  parameter int ADDR_W = 10
) (
  // clock and answer
  input  wire logic              clk_sys_in,
  input  wire logic              waitrequest_in,
  input  wire logic [31:0]       readdata_in,
  // request
  output logic      [ADDR_W-1:0] address_out,
  output logic                   read_out,
  output logic                   write_out,
  output logic      [31:0]       writedata_out,
  output logic      [3:0]        byteenable_out
);
  // idle bus from time zero
  initial begin
    address_out    = '0;
    read_out       = 1'b0;
    write_out      = 1'b0;
    writedata_out  = '0;
    byteenable_out = 4'hF;
  end
  // request held until waitrequest is seen low at an edge, released only after it
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [15:0] wd,
                      input logic [3:0] lanes, output logic [15:0] rd);
    logic w;
    @(posedge clk_sys_in);
    address_out    <= ADDR_W'({idx, 2'b00});
    writedata_out  <= {16'h0000, wd};
    byteenable_out <= lanes;
    write_out      <= wr;
    read_out       <= !wr;
    // no cycle count assumed; only the bench timeout ends a hung wait
    do begin
      @(posedge clk_sys_in);
      w  = waitrequest_in;
      rd = readdata_in[15:0];
    end while (w);
    write_out <= 1'b0;
    read_out  <= 1'b0;
  endtask
endmodule // host_model

// File: verification/status_alarm_sva.sv
// Purpose: port-level checks on the status, summary and bus handshake of the alarm logic
// Assumes: bench keeps service bit 3, fault bit 1, alarm bits 3 and 0 of the masks set
// Notes:   live bits lag inputs one cycle and latches two, so delays below are exact
`timescale 1ns/100ps
module status_alarm_sva (
  // clock, reset and bus
  input wire logic        clk_sys_in, rst_n_in, avs_read_in, avs_write_in, avs_waitrequest_out,
  input wire logic [31:0] avs_readdata_out,
  // conditions
  input wire logic        power_out_fatal_in, locked_in, power_locker_fail_in, temp_out_fatal_in,
  input wire logic        temp_stab_fail_in, freq_out_fatal_in, bias_fatal_in, power_out_warn_in,
  input wire logic        freq_out_warn_in, temp_out_warn_in, bias_warn_in, tuning_in,
  input wire logic        laser_off_in, disable_line_n_in,
  // summaries
  input wire logic        service_request_line_n_out, laser_shutdown_out, alarm_summary_out,
  input wire logic        fault_summary_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  logic calm;
  // nothing can raise a live bit, tuning included since it may force warnings
  assign calm = ~|{power_out_fatal_in, power_locker_fail_in, temp_out_fatal_in, temp_stab_fail_in,
    freq_out_fatal_in, bias_fatal_in, power_out_warn_in, freq_out_warn_in, temp_out_warn_in,
    bias_warn_in, tuning_in, laser_off_in};
  // one wait cycle, then the answer
  sequence s_answer;
    avs_waitrequest_out ##1 !avs_waitrequest_out;
  endsequence
  // live bit one cycle later, latch one more
  sequence s_latched_req;
    ##2 !service_request_line_n_out;
  endsequence
  a_wait_once: assert property ($rose(avs_read_in || avs_write_in) |-> s_answer)
    else $error("access not answered after exactly one wait cycle");
  a_idle_nowait: assert property (!(avs_read_in || avs_write_in) |-> !avs_waitrequest_out)
    else $error("waitrequest without a request");
  a_rd_upper: assert property (avs_read_in && !avs_waitrequest_out |->
    avs_readdata_out[31:16] == 16'h0000) else $error("upper read half not zero");
  a_shut_fault: assert property (laser_shutdown_out |-> fault_summary_out)
    else $error("shutdown without fault summary");
  a_calm_alarm: assert property (calm |=> !alarm_summary_out)
    else $error("alarm summary with no live condition");
  a_bias_alarm: assert property (bias_fatal_in |=> alarm_summary_out)
    else $error("fatal bias did not raise alarm summary");
  a_power_lock: assert property (power_out_fatal_in && locked_in |=> alarm_summary_out)
    else $error("fatal power in lock did not raise alarm summary");
  a_bias_request: assert property (bias_fatal_in |-> s_latched_req)
    else $error("fatal bias latch did not raise service request");
  a_temp_fault: assert property (temp_stab_fail_in |-> ##2 fault_summary_out)
    else $error("stabiliser failure did not raise fault summary");
  a_request_sticky: assert property (!service_request_line_n_out && !avs_write_in &&
    !tuning_in && disable_line_n_in && $past(disable_line_n_in) |=> !service_request_line_n_out)
    else $error("service request dropped without a host write");
endmodule // status_alarm_sva

bind laser_module_status_alarm_logic status_alarm_sva chk (.clk_sys_in, .rst_n_in, .avs_read_in,
  .avs_write_in, .avs_waitrequest_out, .avs_readdata_out, .power_out_fatal_in, .locked_in,
  .power_locker_fail_in, .temp_out_fatal_in, .temp_stab_fail_in, .freq_out_fatal_in,
  .bias_fatal_in, .power_out_warn_in, .freq_out_warn_in, .temp_out_warn_in, .bias_warn_in,
  .tuning_in, .laser_off_in, .disable_line_n_in, .service_request_line_n_out,
  .laser_shutdown_out, .alarm_summary_out, .fault_summary_out);

// File: verification/tb_top.sv
// Purpose: register and summary scenarios for the laser status and alarm logic
// Assumes: mask bits watched by the checker are restored after the mask test
// Notes:   three cycles after a condition change both live bit and latch have settled
`timescale 1ns/100ps
module tb_top;
  logic        clk_sys_in = 1'b0, rst_n_in = 1'b0, rd, wr, wreq, srqn, shut, alarm, flt;
  logic [9:0]  addr;
  logic [31:0] wdata, rdata;
  logic [3:0]  be;
  logic pof = 0, lck = 0, plf = 0, tof = 0, tsf = 0, fof = 0, bf = 0, pow = 0, fow = 0, tow = 0;
  logic bw = 0, tun = 0, loff = 0, disn = 1, xe = 0, ce = 0, cr = 0;
  logic [15:0] mrst [3] = '{16'h1FBF, 16'h000F, 16'h0D0D};
  logic [15:0] mful [3] = '{16'h1FFF, 16'h0F2F, 16'h0F0F};
  int          bad_count = 0, check_count = 0, cycles = 0;

  always #25 clk_sys_in = ~clk_sys_in;

  laser_module_status_alarm_logic #(.ADDR_W(10)) uut (.clk_sys_in, .rst_n_in,
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_byteenable_in(be), .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
    .power_out_fatal_in(pof), .locked_in(lck), .power_locker_fail_in(plf),
    .temp_out_fatal_in(tof), .temp_stab_fail_in(tsf), .freq_out_fatal_in(fof),
    .bias_fatal_in(bf), .power_out_warn_in(pow), .freq_out_warn_in(fow),
    .temp_out_warn_in(tow), .bias_warn_in(bw), .tuning_in(tun), .laser_off_in(loff),
    .disable_line_n_in(disn), .exec_error_pulse_in(xe), .checksum_error_pulse_in(ce),
    .comm_reset_pulse_in(cr), .service_request_line_n_out(srqn), .laser_shutdown_out(shut),
    .alarm_summary_out(alarm), .fault_summary_out(flt));

  host_model #(.ADDR_W(10)) host (.clk_sys_in, .waitrequest_in(wreq), .readdata_in(rdata),
    .address_out(addr), .read_out(rd), .write_out(wr), .writedata_out(wdata),
    .byteenable_out(be));

  task automatic give_verdict();
    if (bad_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_pin(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic rd_chk(input logic [7:0] idx, input logic [15:0] exp);
    logic [15:0] d;
    host.xfer(1'b0, idx, 16'h0000, 4'hF, d);
    chk_word($sformatf("register %h", idx), exp, d);
  endtask
  task automatic wr_reg(input logic [7:0] idx, input logic [15:0] data);
    logic [15:0] d;
    host.xfer(1'b1, idx, data, 4'hF, d);
  endtask
  task automatic wr_be(input logic [7:0] idx, input logic [15:0] data, input logic [3:0] lanes);
    logic [15:0] d;
    host.xfer(1'b1, idx, data, lanes, d);
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask

  // hang guard: the whole run needs a few hundred cycles
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 4000) begin
      bad_count++;
      give_verdict();
    end
  end

  // main sequence; status indices 0x20 fatal, 0x21 warning, 0x33 config
  initial begin
    step(3);
    rst_n_in <= 1'b1;
    rd_chk(8'h20, 16'h8020);
    chk_pin("request line", 1'b0, srqn);
    for (int i = 0; i < 3; i++) begin
      rd_chk(8'h28 + 8'(i), mrst[i]);
      wr_reg(8'h28 + 8'(i), 16'hFFFF);
      rd_chk(8'h28 + 8'(i), mful[i]);
      wr_reg(8'h28 + 8'(i), mrst[i]);
    end
    wr_reg(8'h20, 16'h0F00);
    rd_chk(8'h20, 16'h8020);
    wr_reg(8'h20, 16'h0020);
    rd_chk(8'h20, 16'h0000);
    chk_pin("request line", 1'b1, srqn);
    // fatal bias: live, latch and all three summaries
    bf <= 1'b1;
    step(3);
    rd_chk(8'h20, 16'hE808);
    chk_pin("fault summary", 1'b1, flt);
    bf <= 1'b0;
    step(3);
    rd_chk(8'h20, 16'hA008);
    rd_chk(8'h21, 16'hA000);
    wr_reg(8'h20, 16'h0008);
    rd_chk(8'h20, 16'h0000);
    // shutdown follows fault while enabled
    wr_reg(8'h33, 16'h0002);
    tsf <= 1'b1;
    step(3);
    chk_pin("shutdown", 1'b1, shut);
    rd_chk(8'h20, 16'hA202);
    tsf <= 1'b0;
    wr_reg(8'h20, 16'h0002);
    step(1);
    chk_pin("shutdown", 1'b0, shut);
    wr_reg(8'h33, 16'h0000);
    // warning frequency
    fow <= 1'b1;
    step(3);
    rd_chk(8'h21, 16'hC404);
    fow <= 1'b0;
    wr_reg(8'h21, 16'h0004);
    rd_chk(8'h21, 16'h0000);
    // alarm while tuning: warnings act as lock flags, latch terms held off
    wr_reg(8'h33, 16'h0004);
    tun <= 1'b1;
    step(3);
    rd_chk(8'h21, 16'h4505);
    chk_pin("alarm summary", 1'b1, alarm);
    tun <= 1'b0;
    step(3);
    rd_chk(8'h21, 16'h8005);
    wr_reg(8'h21, 16'h0005);
    wr_reg(8'h33, 16'h0000);
    // event strobes; comm error is off in the default service mask
    xe <= 1'b1;
    ce <= 1'b1;
    cr <= 1'b1;
    step(1);
    xe <= 1'b0;
    ce <= 1'b0;
    cr <= 1'b0;
    step(2);
    rd_chk(8'h20, 16'h80D0);
    wr_reg(8'h20, 16'h00D0);
    ce <= 1'b1;
    step(1);
    ce <= 1'b0;
    step(2);
    rd_chk(8'h20, 16'h0040);
    wr_reg(8'h20, 16'h0040);
    // disable line and fatal power gated by lock
    disn <= 1'b0;
    step(3);
    rd_chk(8'h20, 16'h9000);
    disn <= 1'b1;
    pof <= 1'b1;
    step(3);
    rd_chk(8'h20, 16'h0000);
    lck <= 1'b1;
    step(3);
    rd_chk(8'h20, 16'hE101);
    pof <= 1'b0;
    wr_reg(8'h20, 16'h0001);
    wr_reg(8'hFF, 16'hFFFF);
    rd_chk(8'hFF, 16'h0000);
    rd_chk(8'h20, 16'h0000);
    // remaining fatal sources; a clear with lane 0 off must not land
    plf <= 1'b1;
    fof <= 1'b1;
    tof <= 1'b1;
    step(3);
    rd_chk(8'h20, 16'hE707);
    plf <= 1'b0;
    fof <= 1'b0;
    tof <= 1'b0;
    wr_be(8'h20, 16'h0007, 4'h2);
    rd_chk(8'h20, 16'hA007);
    wr_reg(8'h20, 16'h0007);
    // remaining warning sources, then laser off with alarm-while-tuning
    pow <= 1'b1;
    tow <= 1'b1;
    bw  <= 1'b1;
    step(3);
    rd_chk(8'h21, 16'hCB0B);
    pow <= 1'b0;
    tow <= 1'b0;
    bw  <= 1'b0;
    wr_reg(8'h21, 16'h000B);
    wr_reg(8'h33, 16'h0004);
    loff <= 1'b1;
    step(3);
    rd_chk(8'h21, 16'hC505);
    loff <= 1'b0;
    wr_reg(8'h33, 16'h0000);
    wr_reg(8'h21, 16'h0005);
    rd_chk(8'h21, 16'h0000);
    give_verdict();
  end
endmodule // tb_top

// File: verilog/laser_module_status_alarm_logic.sv
// Purpose: status words, trigger masks and summary bits for the laser module
// Assumes: condition inputs synchronous to clk_sys_in; Avalon-MM slave
// Notes:   every access takes two cycles; live bits lag their inputs one cycle
//
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/100ps
module laser_module_status_alarm_logic #(
  parameter int ADDR_W = 10
) (
  // clock and reset
  input  wire logic              clk_sys_in,
  input  wire logic              rst_n_in,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0] avs_address_in,
  input  wire logic              avs_read_in,
  input  wire logic              avs_write_in,
  input  wire logic [31:0]       avs_writedata_in,
  input  wire logic [3:0]        avs_byteenable_in,
  output logic      [31:0]       avs_readdata_out,
  output logic                   avs_waitrequest_out,
  // fatal conditions
  input  wire logic              power_out_fatal_in,
  input  wire logic              locked_in,
  input  wire logic              power_locker_fail_in,
  input  wire logic              temp_out_fatal_in,
  input  wire logic              temp_stab_fail_in,
  input  wire logic              freq_out_fatal_in,
  input  wire logic              bias_fatal_in,
  // warning conditions
  input  wire logic              power_out_warn_in,
  input  wire logic              freq_out_warn_in,
  input  wire logic              temp_out_warn_in,
  input  wire logic              bias_warn_in,
  // laser state
  input  wire logic              tuning_in,
  input  wire logic              laser_off_in,
  input  wire logic              disable_line_n_in,
  // event strobes
  input  wire logic              exec_error_pulse_in,
  input  wire logic              checksum_error_pulse_in,
  input  wire logic              comm_reset_pulse_in,
  // summary outputs
  output logic                   service_request_line_n_out,
  output logic                   laser_shutdown_out,
  output logic                   alarm_summary_out,
  output logic                   fault_summary_out
);

  // refuse address widths that cannot reach every 8-bit register index, up to 0xFF
  if (ADDR_W < 10) begin : g_addr_check
    $error("ADDR_W must be at least 10");
  end

  typedef struct packed {
    laser_alarm_pkg::bus_state_t bus;
    logic [15:0]                 rdata;
    logic [15:0]                 srv_mask;
    logic [15:0]                 flt_mask;
    logic [15:0]                 alarm_mask;
    logic [15:0]                 cfg;
    logic [3:0]                  fatal_live;
    logic [3:0]                  warn_live;
    logic                        out_off;
    logic                        tuning;
  } state_t;

  state_t      q;
  state_t      d;

  logic [3:0]  fatal_latch;
  logic [3:0]  warn_latch;
  logic [3:0]  misc_latch;
  logic [3:0]  fatal_clr;
  logic [3:0]  warn_clr;
  logic [3:0]  misc_clr;
  logic [3:0]  misc_set;
  logic [3:0]  fatal_cond;
  logic [3:0]  warn_cond;
  logic        request;
  logic        in_range;
  logic [7:0]  word_idx;
  logic        write_fire;
  logic        lane_lo;
  logic        lane_hi;
  logic [15:0] wdata;
  logic        shut_en;
  logic        tune_alarm;
  logic        tune_quiet;
  logic        service_req;
  logic        alarm_sum;
  logic        fault;
  logic [15:0] fatal_word;
  logic [15:0] warn_word;
  logic [15:0] rd_mux;

  // address decode; anything outside the window is unmapped
  assign request    = avs_read_in | avs_write_in;
  assign in_range   = (avs_address_in >> 10) == '0;
  assign word_idx   = 8'(avs_address_in >> 2);
  assign write_fire = avs_write_in & (q.bus == laser_alarm_pkg::BUS_ACK);
  assign lane_lo    = avs_byteenable_in[0];
  assign lane_hi    = avs_byteenable_in[1];
  assign wdata      = avs_writedata_in[15:0];

  // waitrequest drops in the second cycle of each access
  assign avs_waitrequest_out = request & (q.bus == laser_alarm_pkg::BUS_IDLE);

  // configuration bits
  assign shut_en    = q.cfg[laser_alarm_pkg::CFG_SHUTDOWN_BIT];
  assign tune_alarm = q.cfg[laser_alarm_pkg::CFG_TUNE_ALARM_BIT];
  // warnings mean not-locked while tuning, so keep them off service request and fault then
  assign tune_quiet = q.tuning & tune_alarm;

  // fatal conditions, nibble order bias, freq, temp, power
  assign fatal_cond[3] = bias_fatal_in;
  assign fatal_cond[2] = freq_out_fatal_in;
  assign fatal_cond[1] = temp_out_fatal_in | temp_stab_fail_in;
  assign fatal_cond[0] = (power_out_fatal_in & locked_in) | power_locker_fail_in;

  // with alarm-while-tuning, freq and power warnings report not-locked while tuning or off
  assign warn_cond[3] = bias_warn_in;
  assign warn_cond[2] = freq_out_warn_in | (tune_alarm & (tuning_in | laser_off_in));
  assign warn_cond[1] = temp_out_warn_in;
  assign warn_cond[0] = power_out_warn_in | (tune_alarm & (tuning_in | laser_off_in));

  // alarm summary from live bits
  assign alarm_sum = |(q.alarm_mask[11:8] & q.warn_live)
                   | |(q.alarm_mask[3:0] & q.fatal_live);

  // fault summary from latches
  assign fault = (|(q.flt_mask[11:8] & warn_latch) & ~tune_quiet)
               | |(q.flt_mask[3:0] & fatal_latch)
               | (q.flt_mask[laser_alarm_pkg::BIT_RESTART] & misc_latch[1]);

  // service request summary from latches and output-off
  assign service_req = (|(q.srv_mask[11:8] & warn_latch) & ~tune_quiet)
                     | |(q.srv_mask[3:0] & fatal_latch)
                     | (q.srv_mask[laser_alarm_pkg::BIT_OUT_OFF] & q.out_off)
                     | |(q.srv_mask[7:4] & misc_latch);

  // status words share summaries, output-off and misc latches
  assign fatal_word = {service_req, alarm_sum, fault, q.out_off,
                       q.fatal_live, misc_latch, fatal_latch};
  assign warn_word  = {service_req, alarm_sum, fault, q.out_off,
                       q.warn_live, misc_latch, warn_latch};

  // read multiplexer; unmapped reads return zero
  always_comb begin
    rd_mux = 16'h0000;
    if (!in_range) begin
      rd_mux = 16'h0000;
    end else if (word_idx == laser_alarm_pkg::IDX_FATAL_STATUS) begin
      rd_mux = fatal_word;
    end else if (word_idx == laser_alarm_pkg::IDX_WARN_STATUS) begin
      rd_mux = warn_word;
    end else if (word_idx == laser_alarm_pkg::IDX_SERVICE_MASK) begin
      rd_mux = q.srv_mask;
    end else if (word_idx == laser_alarm_pkg::IDX_FAULT_MASK) begin
      rd_mux = q.flt_mask;
    end else if (word_idx == laser_alarm_pkg::IDX_ALARM_MASK) begin
      rd_mux = q.alarm_mask;
    end else if (word_idx == laser_alarm_pkg::IDX_CONFIG) begin
      rd_mux = q.cfg;
    end
  end

  // write-one clears; only the latch positions of the low byte respond
  always_comb begin
    fatal_clr = 4'h0;
    warn_clr  = 4'h0;
    misc_clr  = 4'h0;
    if (write_fire && in_range && lane_lo) begin
      if (word_idx == laser_alarm_pkg::IDX_FATAL_STATUS) begin
        fatal_clr = wdata[3:0];
        misc_clr  = wdata[7:4];
      end else if (word_idx == laser_alarm_pkg::IDX_WARN_STATUS) begin
        warn_clr  = wdata[3:0];
        misc_clr  = wdata[7:4];
      end
    end
  end

  // shared latch sources, order exec error, comm error, restart, comm reset
  assign misc_set = {exec_error_pulse_in,
                     checksum_error_pulse_in,
                     1'b0,
                     comm_reset_pulse_in};

  // next state: bus handshake, masks, config and live bits
  always_comb begin
    d            = q;
    d.fatal_live = fatal_cond;
    d.warn_live  = warn_cond;
    d.out_off    = ~disable_line_n_in;
    d.tuning     = tuning_in;
    case (q.bus)
      laser_alarm_pkg::BUS_IDLE: begin
        if (request) begin
          d.bus   = laser_alarm_pkg::BUS_ACK;
          d.rdata = avs_read_in ? rd_mux : 16'h0000;
        end
      end
      laser_alarm_pkg::BUS_ACK: begin
        d.bus = laser_alarm_pkg::BUS_IDLE;
      end
      default: begin
        d.bus = laser_alarm_pkg::BUS_IDLE;
      end
    endcase
    if (write_fire && in_range) begin
      if (word_idx == laser_alarm_pkg::IDX_SERVICE_MASK) begin
        d.srv_mask = merge(q.srv_mask, wdata, laser_alarm_pkg::SERVICE_MASK_WR);
      end else if (word_idx == laser_alarm_pkg::IDX_FAULT_MASK) begin
        d.flt_mask = merge(q.flt_mask, wdata, laser_alarm_pkg::FAULT_MASK_WR);
      end else if (word_idx == laser_alarm_pkg::IDX_ALARM_MASK) begin
        d.alarm_mask = merge(q.alarm_mask, wdata, laser_alarm_pkg::ALARM_MASK_WR);
      end else if (word_idx == laser_alarm_pkg::IDX_CONFIG) begin
        d.cfg      = merge(q.cfg, wdata, laser_alarm_pkg::CONFIG_WR);
      end
    end
  end

  // byte-lane merge limited to the writable bits
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] val,
                                        input logic [15:0] wr);
    logic [15:0] lanes;
    lanes = {{8{lane_hi}}, {8{lane_lo}}} & wr;
    return (old & ~lanes) | (val & lanes);
  endfunction

  // state register
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      q.bus        <= laser_alarm_pkg::BUS_IDLE;
      q.rdata      <= 16'h0000;
      q.srv_mask   <= laser_alarm_pkg::SERVICE_MASK_RST;
      q.flt_mask   <= laser_alarm_pkg::FAULT_MASK_RST;
      q.alarm_mask <= laser_alarm_pkg::ALARM_MASK_RST;
      q.cfg        <= laser_alarm_pkg::CONFIG_RST;
      q.fatal_live <= 4'h0;
      q.warn_live  <= 4'h0;
      q.out_off    <= 1'b0;
      q.tuning     <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // fatal latches follow the registered live bits
  sticky_latch #(
    .W   (4),
    .RST (laser_alarm_pkg::LATCH_RST)
  ) u_fatal_latch (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .set_in     (q.fatal_live),
    .clr_in     (fatal_clr),
    .flags_out  (fatal_latch)
  );

  // warning latches
  sticky_latch #(
    .W   (4),
    .RST (laser_alarm_pkg::LATCH_RST)
  ) u_warn_latch (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .set_in     (q.warn_live),
    .clr_in     (warn_clr),
    .flags_out  (warn_latch)
  );

  // shared latches; restart comes up set since reset is a restart
  sticky_latch #(
    .W   (4),
    .RST (laser_alarm_pkg::MISC_LATCH_RST)
  ) u_misc_latch (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .set_in     (misc_set),
    .clr_in     (misc_clr),
    .flags_out  (misc_latch)
  );

  // bus read data from the flop, upper half reserved
  assign avs_readdata_out = {16'h0000, q.rdata};

  // request line active low
  assign service_request_line_n_out = ~service_req;

  // shutdown only when enabled in config
  assign laser_shutdown_out = shut_en & fault;

  // summaries also brought out for the rest of the module
  assign alarm_summary_out = alarm_sum;
  assign fault_summary_out = fault;

endmodule // laser_module_status_alarm_logic

// File: verilog/sticky_latch.sv
// Purpose: vector of sticky flags, set by hardware, cleared by write-one
// Assumes: clear is a one-cycle qualified strobe; set may be a held level such as a live bit
// Notes:   set wins over a clear in the same cycle
`timescale 1ns/100ps
module sticky_latch #(
  parameter int         W   = 4,
  parameter logic [W-1:0] RST = '0
) (
  // clock and reset
  input  wire logic         clk_sys_in,
  input  wire logic         rst_n_in,
  // flag control
  input  wire logic [W-1:0] set_in,
  input  wire logic [W-1:0] clr_in,
  output logic      [W-1:0] flags_out
);

  // refuse an empty flag vector
  if (W < 1) begin : g_width_check
    $error("W must be at least 1");
  end

  typedef struct packed {
    logic [W-1:0] flags;
  } latch_state_t;

  latch_state_t q;
  latch_state_t d;

  // clear only where a 1 is written, never where a set is active
  always_comb begin
    d       = q;
    d.flags = (q.flags & ~clr_in) | set_in;
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      q.flags <= RST;
    end else begin
      q <= d;
    end
  end

  assign flags_out = q.flags;

endmodule // sticky_latch
